// File: common/bmfr_pkg.sv
// Package for the bus management initial mask and fairness register bank.
// Assumes a 32-bit APB slave port with word-aligned byte addresses.
package bmfr_pkg;
  // -----------------------------------------------------------------
  // Register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0]  OFS_INIT_MASK_UPPER = 8'hb4;
  localparam logic [7:0]  OFS_INIT_MASK_LOWER = 8'hb8;
  localparam logic [7:0]  OFS_FAIRNESS_LIMIT  = 8'hdc;
  localparam logic [7:0]  OFS_RESET_CONTROL   = 8'he8;
  localparam logic [7:0]  OFS_CHAN_AVAIL_UPPER = 8'hec;
  localparam logic [7:0]  OFS_CHAN_AVAIL_LOWER = 8'hf0;
  localparam logic [7:0]  OFS_PRI_REQ_STATUS  = 8'hf4;
  // -----------------------------------------------------------------
  // Reset values and fields
  // -----------------------------------------------------------------
  localparam logic [31:0] RST_INIT_MASK       = 32'hffffffff;
  localparam logic [7:0]  RST_FAIRNESS_LIMIT  = 8'h00;
  localparam int          LIMIT_MSB           = 7;
  localparam int          SOFT_RESET_BIT      = 0;
endpackage

// File: logic/bmfr_pri_gate.sv
// Counts priority arbitration requests in one fairness interval.
// Assumes request and interval strobes come from logic on ref_clk.
module bmfr_pri_gate #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] limit,
  input  wire logic             interval_start,
  input  wire logic             pri_req_want,
  output logic                  pri_req_grant,
  output logic [WIDTH-1:0]      pri_count
);
  // -----------------------------------------------------------------
  // Request counter
  // -----------------------------------------------------------------
  logic             allow;
  logic [WIDTH-1:0] next_count;

  // Issue only while the count is below the limit
  assign allow      = (pri_count < limit);
  assign next_count = interval_start ? '0 :
                      (pri_req_want && allow) ? pri_count + 1'b1 : pri_count;

  // [RULE7] count and stop
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pri_count     <= '0;
      pri_req_grant <= 1'b0;
    end else begin
      pri_count     <= next_count;
      pri_req_grant <= pri_req_want && allow && !interval_start;
    end
  end

  // [RULE7] limit never exceeded
  chk_count_limit: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE7]
    pri_req_grant |-> ($past(pri_count) < $past(limit) &&
                       pri_count == $past(pri_count) + 1'b1))
    else $error("priority grant beyond limit");
  // [RULE7] interval restarts count
  chk_count_restart: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE7]
    interval_start |=> (pri_count == '0 && !pri_req_grant))
    else $error("count not restarted");
endmodule // bmfr_pri_gate

// File: logic/bmfr_regs.sv
// APB register bank: initial channel masks and fairness limit.
// Assumes reset strobes are one-cycle pulses on ref_clk.
//
// Summary of operation
// [RULE1] Masks reset to all ones, bus reset keeps
// [RULE2] Resets copy upper mask into CSR
// [RULE3] Resets copy lower mask into CSR
// [RULE4] Hardware or software reset also copies
// [RULE5] Eight-bit read/write priority request limit
// [RULE6] Fairness bits 31-8 read zero
// [RULE7] Count requests, stop at limit, restart
//
// Register access over APB was chosen for this implementation.
module bmfr_regs
  import bmfr_pkg::*;
#(
  parameter int LIMIT_W = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        host_bus_reset,
  input  wire logic        bus_1394_reset,
  input  wire logic        fairness_interval,
  input  wire logic        pri_req_want,
  output logic             pri_req_grant,
  output logic [31:0]      chan_avail_upper,
  output logic [31:0]      chan_avail_lower
);
  import bmfr_pkg::*;

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  logic [31:0]        init_mask_upper;
  logic [31:0]        init_mask_lower;
  logic [LIMIT_W-1:0] async_fairness_limit;
  logic [LIMIT_W-1:0] pri_count;
  logic               soft_reset;
  logic               load_pending;
  logic               wr_en;
  logic               rd_en;
  logic               hit;
  logic               mask_reset;
  logic               copy_now;
  logic [31:0]        rd_mux;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Writes land only at the edge that completes the access (pready high),
  // so a software reset strobe fires once per transfer
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite;
  assign hit   = sel(paddr, OFS_INIT_MASK_UPPER) || sel(paddr, OFS_INIT_MASK_LOWER) ||
                 sel(paddr, OFS_FAIRNESS_LIMIT) || sel(paddr, OFS_RESET_CONTROL) ||
                 sel(paddr, OFS_CHAN_AVAIL_UPPER) || sel(paddr, OFS_CHAN_AVAIL_LOWER) ||
                 sel(paddr, OFS_PRI_REQ_STATUS);
  // Software reset is a write of one to the reset control bit
  assign soft_reset = wr_en && sel(paddr, OFS_RESET_CONTROL) && pwdata[SOFT_RESET_BIT];
  // [RULE1] bus reset spares masks
  assign mask_reset = soft_reset || host_bus_reset;
  // [RULE4] every reset kind copies
  // Host and software resets copy via load_pending a cycle later, so the
  // CSRs end up with the fresh masks, not the stale ones the reset is about to clear
  assign copy_now   = load_pending || bus_1394_reset;

  // [RULE6] reserved bits read zero
  assign rd_mux =
    sel(paddr, OFS_INIT_MASK_UPPER)  ? init_mask_upper :
    sel(paddr, OFS_INIT_MASK_LOWER)  ? init_mask_lower :
    sel(paddr, OFS_FAIRNESS_LIMIT)   ? {{(32-LIMIT_W){1'b0}}, async_fairness_limit} :
    sel(paddr, OFS_CHAN_AVAIL_UPPER) ? chan_avail_upper :
    sel(paddr, OFS_CHAN_AVAIL_LOWER) ? chan_avail_lower :
    sel(paddr, OFS_PRI_REQ_STATUS)   ? {{(32-LIMIT_W){1'b0}}, pri_count} : 32'h00000000;

  // -----------------------------------------------------------------
  // Initial masks and fairness limit
  // -----------------------------------------------------------------
  // [RULE1] masks reset to ones
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_mask_upper <= RST_INIT_MASK;
      init_mask_lower <= RST_INIT_MASK;
    end else if (mask_reset) begin
      init_mask_upper <= RST_INIT_MASK;
      init_mask_lower <= RST_INIT_MASK;
    end else if (wr_en && sel(paddr, OFS_INIT_MASK_UPPER)) begin
      init_mask_upper <= pwdata;
    end else if (wr_en && sel(paddr, OFS_INIT_MASK_LOWER)) begin
      init_mask_lower <= pwdata;
    end
  end

  // [RULE5] eight-bit limit field
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      async_fairness_limit <= RST_FAIRNESS_LIMIT;
    end else if (mask_reset) begin
      async_fairness_limit <= RST_FAIRNESS_LIMIT;
    end else if (wr_en && sel(paddr, OFS_FAIRNESS_LIMIT)) begin
      async_fairness_limit <= pwdata[LIMIT_MSB:0];
    end
  end

  // -----------------------------------------------------------------
  // Channels available CSR copy
  // -----------------------------------------------------------------
  // Copy one cycle after a mask reset, so the fresh ones are moved,
  // and straight after pin reset release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= mask_reset;
    end
  end

  // [RULE2] [RULE3] copy both masks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      chan_avail_upper <= RST_INIT_MASK;
      chan_avail_lower <= RST_INIT_MASK;
    end else if (copy_now) begin
      chan_avail_upper <= init_mask_upper;
      chan_avail_lower <= init_mask_lower;
    end
  end

  // -----------------------------------------------------------------
  // APB answer
  // -----------------------------------------------------------------
  // Outputs registered: pready rises in the first access cycle + 1
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      prdata  <= (rd_en && !pready) ? rd_mux : 32'h00000000;
    end
  end

  // -----------------------------------------------------------------
  // Priority request gate
  // -----------------------------------------------------------------
  bmfr_pri_gate #(
    .WIDTH          (LIMIT_W)
  ) u_gate (
    .ref_clk        (ref_clk),
    .resetn         (resetn),
    .limit          (async_fairness_limit),
    .interval_start (fairness_interval),
    .pri_req_want   (pri_req_want),
    .pri_req_grant  (pri_req_grant),
    .pri_count      (pri_count)
  );

  // [RULE2] bus reset copies upper
  chk_copy_upper: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE2]
    (bus_1394_reset && !mask_reset) |=> chan_avail_upper == $past(init_mask_upper))
    else $error("upper CSR not loaded");
  // [RULE3] bus reset copies lower
  chk_copy_lower: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE3]
    (bus_1394_reset && !mask_reset) |=> chan_avail_lower == $past(init_mask_lower))
    else $error("lower CSR not loaded");
  // [RULE1] bus reset keeps upper mask
  chk_mask_keep: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE1]
    (bus_1394_reset && !mask_reset && !wr_en) |=> $stable(init_mask_upper))
    else $error("bus reset changed mask");
  // [RULE4] soft reset reloads CSR
  chk_soft_copy: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE4]
    mask_reset |=> ##1 (chan_avail_upper == RST_INIT_MASK &&
                        chan_avail_lower == RST_INIT_MASK))
    else $error("soft reset copy missing");
  // [RULE6] reserved bits read zero
  chk_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE6]
    (rd_en && !pready && sel(paddr, OFS_FAIRNESS_LIMIT)) |=> prdata[31:8] == 24'h000000)
    else $error("reserved fairness bits nonzero");
  // [RULE5] limit write stored
  chk_limit_write: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE5]
    (wr_en && sel(paddr, OFS_FAIRNESS_LIMIT) && !mask_reset)
      |=> async_fairness_limit == $past(pwdata[7:0]))
    else $error("limit write lost");

  // -----------------------------------------------------------------
  // Further checks on masks, CSRs, the fairness limit and the bus answer
  // -----------------------------------------------------------------
  // [RULE1] bus reset keeps lower
  chk_keep_lower: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE1]
    (bus_1394_reset && !mask_reset && !wr_en) |=> $stable(init_mask_lower))
    else $error("bus reset changed lower mask");
  // [RULE1] resets restore ones
  chk_mask_ones: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE1]
    mask_reset |=> (init_mask_upper == RST_INIT_MASK && init_mask_lower == RST_INIT_MASK))
    else $error("mask not restored to ones");
  // [RULE2] CSR moves on copy
  chk_csr_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE2]
    !copy_now |=> ($stable(chan_avail_upper) && $stable(chan_avail_lower)))
    else $error("channels CSR changed without a copy");
  // [RULE5] limit holds between writes
  chk_limit_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE5]
    (!(wr_en && sel(paddr, OFS_FAIRNESS_LIMIT)) && !mask_reset)
      |=> $stable(async_fairness_limit))
    else $error("limit changed without a write");
  // Unmapped access is answered with an error
  chk_err_unmapped: assert property (@(posedge ref_clk) disable iff (!resetn)
    (psel && penable && !pready && !hit) |=> (pready && pslverr))
    else $error("unmapped access not refused");
  // One answer pulse per transfer
  chk_ready_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");
endmodule // bmfr_regs

// File: testbench/bmfr_regs_tb.sv
// Self-checking bench for the initial channel mask and fairness register bank.
// Assumes bmfr_pkg is compiled first; the bench is APB master and link side.
module bus_mgmt_init_and_fairness_regs_tb_top import bmfr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, resetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, chan_avail_upper, chan_avail_lower, rd, g;
  logic        pready, pslverr, host_bus_reset, bus_1394_reset, er;
  logic        fairness_interval, pri_req_want, pri_req_grant;
  int          num_errors, checks_done;
  // ----------------------------------------------------------------
  // Clock, design and watchdog
  // ----------------------------------------------------------------
  // 200 MHz clock
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;
  bmfr_regs #(.LIMIT_W(8)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_bus_reset(host_bus_reset), .bus_1394_reset(bus_1394_reset),
    .fairness_interval(fairness_interval), .pri_req_want(pri_req_want),
    .pri_req_grant(pri_req_grant), .chan_avail_upper(chan_avail_upper),
    .chan_avail_lower(chan_avail_lower));
  // Tests need well under 1000 cycles, so a hang is cut at 20 us
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb_xfer(1'b0, a, 32'h00000000);
    check(nm, rd, exp);
  endtask
  // Holds the request line for a span and counts the grants seen
  task automatic count_grants(input int cyc);
    g = 32'h00000000;
    pri_req_want <= 1'b1;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (pri_req_grant === 1'b1) g = g + 32'h1;
    end
    pri_req_want <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    host_bus_reset = 1'b0;
    bus_1394_reset = 1'b0;
    fairness_interval = 1'b0;
    pri_req_want = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd_chk(OFS_INIT_MASK_UPPER, 32'hffffffff, "mask_upper_rst");
    check("mapped_err", {31'h0, er}, 32'h0);
    rd_chk(OFS_INIT_MASK_LOWER, 32'hffffffff, "mask_lower_rst");
    rd_chk(OFS_FAIRNESS_LIMIT, 32'h00000000, "limit_rst");
    check("csr_upper_rst", chan_avail_upper, 32'hffffffff);
    check("csr_lower_rst", chan_avail_lower, 32'hffffffff);
    // Bus reset copies new masks and leaves the masks alone
    apb_xfer(1'b1, OFS_INIT_MASK_UPPER, 32'h12345678);
    apb_xfer(1'b1, OFS_INIT_MASK_LOWER, 32'h9abcdef0);
    check("csr_upper_early", chan_avail_upper, 32'hffffffff);
    @(posedge ref_clk) bus_1394_reset <= 1'b1;
    @(posedge ref_clk) bus_1394_reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("csr_upper_bus", chan_avail_upper, 32'h12345678);
    check("csr_lower_bus", chan_avail_lower, 32'h9abcdef0);
    rd_chk(OFS_INIT_MASK_UPPER, 32'h12345678, "mask_upper_bus");
    rd_chk(OFS_INIT_MASK_LOWER, 32'h9abcdef0, "mask_lower_bus");
    rd_chk(OFS_CHAN_AVAIL_UPPER, 32'h12345678, "csr_upper_rd");
    rd_chk(OFS_CHAN_AVAIL_LOWER, 32'h9abcdef0, "csr_lower_rd");
    // Reserved fairness bits ignore writes
    apb_xfer(1'b1, OFS_FAIRNESS_LIMIT, 32'hffffff03);
    rd_chk(OFS_FAIRNESS_LIMIT, 32'h00000003, "limit_rw");
    count_grants(10);
    check("grants_lim3", g, 32'h3);
    rd_chk(OFS_PRI_REQ_STATUS, 32'h00000003, "pri_count_lim3");
    @(posedge ref_clk) fairness_interval <= 1'b1;
    @(posedge ref_clk) fairness_interval <= 1'b0;
    count_grants(10);
    check("grants_new_iv", g, 32'h3);
    // Unmapped address is refused
    rd_chk(8'h40, 32'h00000000, "unmapped_data");
    check("unmapped_err", {31'h0, er}, 32'h1);
    // Software reset restores masks and reloads the CSRs
    apb_xfer(1'b1, OFS_RESET_CONTROL, 32'h00000001);
    repeat (3) @(posedge ref_clk);
    check("csr_upper_sw", chan_avail_upper, 32'hffffffff);
    check("csr_lower_sw", chan_avail_lower, 32'hffffffff);
    rd_chk(OFS_INIT_MASK_UPPER, 32'hffffffff, "mask_upper_sw");
    rd_chk(OFS_INIT_MASK_LOWER, 32'hffffffff, "mask_lower_sw");
    rd_chk(OFS_FAIRNESS_LIMIT, 32'h00000000, "limit_sw");
    count_grants(6);
    check("grants_lim0", g, 32'h0);
    // Host-bus reset behaves like the software reset
    apb_xfer(1'b1, OFS_INIT_MASK_UPPER, 32'h0000a5a5);
    @(posedge ref_clk) host_bus_reset <= 1'b1;
    @(posedge ref_clk) host_bus_reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd_chk(OFS_INIT_MASK_UPPER, 32'hffffffff, "mask_upper_hb");
    check("csr_upper_hb", chan_avail_upper, 32'hffffffff);
    check("csr_lower_hb", chan_avail_lower, 32'hffffffff);
    // Pin reset in mid-run restores the lower mask and reloads the lower CSR
    apb_xfer(1'b1, OFS_INIT_MASK_LOWER, 32'h0f0f0f0f);
    @(posedge ref_clk) bus_1394_reset <= 1'b1;
    @(posedge ref_clk) bus_1394_reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("csr_lower_bus2", chan_avail_lower, 32'h0f0f0f0f);
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("csr_lower_pin", chan_avail_lower, 32'hffffffff);
    rd_chk(OFS_INIT_MASK_LOWER, 32'hffffffff, "mask_lower_pin");
    finish_test();
  end
endmodule // bus_mgmt_init_and_fairness_regs_tb_top
